/* File: erie_top.sv */
// Purpose: Error record control enables and interrupt/abort outputs
// Assumes: Single clock; event inputs are same-domain logic
// Notes:   Reset values are architecturally unknown; zero is used
//
// What this block does
// - Bit 13 of control register enables the critical error interrupt.
// - Critical feature present and enabled: raise critical interrupt on critical error.
// - Critical enable clear: no interrupt, critical error reported as uncontained.
// - Split deferred feature: bit 11 enables recovery interrupt for write deferred errors.
// - Combined deferred feature: bit 10 enables recovery interrupt for all deferred errors.
// - Split deferred feature: bit 10 enables recovery interrupt for read deferred errors.
// - Interrupts fire even when the syndrome is dropped for higher priority.
// - Split corrected feature: bit 9 gates write corrected or overflow fault interrupt.
// - Combined corrected feature: bit 8 gates all corrected or overflow fault interrupt.
// - Split corrected feature: bit 8 gates read corrected or overflow fault interrupt.
// - Split in-band feature: bit 7 gives external abort on write uncorrected errors.
// - Split fault feature: bit 6 gates write deferred/uncorrected fault interrupt.
// - Split recovery feature: bit 5 gates write non-deferred uncorrected recovery interrupt.
// - Combined in-band feature: bit 4 gives external abort on any uncorrected error.
// - Enables reset on cold reset and hold across error recovery reset.
// - Unimplemented controls read as zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module erie_top
  import erie_pkg::*;
(
  // Clock, cold reset, enable
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_rst,
  input  wire logic                 i_ce,
  input  wire logic                 i_err_recov_rst,
  // Feature descriptor
  input  wire erie_feat_t           i_feat,
  input  wire logic                 i_cnt_present,
  // Register port
  input  wire logic                 i_ctl_wr,
  input  wire logic [CTL_WIDTH-1:0] i_ctl_wdata,
  output logic      [CTL_WIDTH-1:0] o_ctl_rdata,
  // Error event
  input  wire logic                 i_ev_valid,
  input  wire erie_class_t          i_ev_class,
  input  wire logic                 i_ev_write,
  input  wire logic                 i_ev_crit,
  input  wire logic                 i_ev_ovf,
  input  wire logic                 i_ev_syn_dropped,
  // Outputs to interrupt controller and requester
  output logic                      o_crit_irq,
  output logic                      o_recov_irq,
  output logic                      o_fault_irq,
  output logic                      o_ext_abort,
  output logic                      o_uncontained
);
  typedef struct packed {
    logic [CTL_WIDTH-1:0] ctl;
    logic                 crit;
    logic                 recov;
    logic                 fault;
    logic                 abort;
    logic                 uncont;
  } erie_state_t;

  erie_state_t          st;
  erie_state_t          next_st;
  logic [CTL_WIDTH-1:0] impl_mask;
  erie_ev_if            ev ();

  always_comb
  begin
    impl_mask = '0;
    impl_mask[CTL_CRIT_EN_BIT] = (i_feat.crit == FEAT_COMBINED);
    impl_mask[CTL_DEF_WR_BIT]  = (i_feat.defer == FEAT_SPLIT);
    impl_mask[CTL_DEF_RD_BIT]  = (i_feat.defer == FEAT_COMBINED) || (i_feat.defer == FEAT_SPLIT);
    impl_mask[CTL_COR_WR_BIT]  = (i_feat.corr == FEAT_SPLIT);
    impl_mask[CTL_COR_RD_BIT]  = (i_feat.corr == FEAT_COMBINED) || (i_feat.corr == FEAT_SPLIT);
    impl_mask[CTL_ABT_WR_BIT]  = (i_feat.abort == FEAT_SPLIT);
    impl_mask[CTL_FLT_WR_BIT]  = (i_feat.fault == FEAT_SPLIT);
    impl_mask[CTL_UNC_WR_BIT]  = (i_feat.uncorr == FEAT_SPLIT);
    impl_mask[CTL_ABT_RD_BIT]  = (i_feat.abort == FEAT_COMBINED) || (i_feat.abort == FEAT_SPLIT);
  end

  // syndrome drop is ignored by qualification
  erie_decode u_decode (
    .i_ctl         (st.ctl & impl_mask),
    .i_feat        (i_feat),
    .i_cnt_present (i_cnt_present),
    .i_ev_valid    (i_ev_valid),
    .i_ev_class    (i_ev_class),
    .i_ev_write    (i_ev_write),
    .i_ev_crit     (i_ev_crit),
    .i_ev_ovf      (i_ev_ovf),
    .ev            (ev.src)
  );

  always_comb
  begin
    next_st        = st;
    // error recovery reset leaves enables alone
    if (i_ctl_wr)
      next_st.ctl  = i_ctl_wdata;
    // reserved bits never hold a one, so the read port is a plain flop
    next_st.ctl    = next_st.ctl & impl_mask;
    next_st.crit   = ev.crit_irq;
    next_st.recov  = ev.recov_irq;
    next_st.fault  = ev.fault_irq;
    next_st.abort  = ev.abort;
    // critical error without enable becomes uncontained
    next_st.uncont = i_ev_valid && i_ev_crit &&
                     !(st.ctl[CTL_CRIT_EN_BIT] && impl_mask[CTL_CRIT_EN_BIT]);
  end

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      st <= '{ctl: CTL_RESET, default: 1'b0};
    else if (i_ce)
      st <= next_st;
  end

  assign o_crit_irq    = st.crit;
  assign o_recov_irq   = st.recov;
  assign o_fault_irq   = st.fault;
  assign o_ext_abort   = st.abort;
  assign o_uncontained = st.uncont;
  assign o_ctl_rdata   = st.ctl;

  logic unused_ok;
  assign unused_ok = i_err_recov_rst ^ i_ev_syn_dropped;

  chk_crit_irq_gate: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && i_ev_valid && i_ev_crit && st.ctl[CTL_CRIT_EN_BIT]
     && i_feat.crit == FEAT_COMBINED)
      |=> o_crit_irq) else $error("critical irq missing");
  chk_crit_uncont: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && i_ev_valid && i_ev_crit && !st.ctl[CTL_CRIT_EN_BIT])
      |=> (o_uncontained && !o_crit_irq))
    else $error("critical not uncontained");
  chk_wr_abort: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && i_ev_valid && i_ev_class == ERIE_UNCORR && i_ev_write
     && i_feat.abort == FEAT_SPLIT && st.ctl[CTL_ABT_WR_BIT])
      |=> o_ext_abort) else $error("write abort missing");
  chk_abort_all: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && i_ev_valid && i_ev_class == ERIE_UNCORR && i_feat.abort == FEAT_COMBINED
     && st.ctl[CTL_ABT_RD_BIT]) |=> o_ext_abort) else $error("abort missing");
  chk_defer_wr: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && i_ev_valid && i_ev_class == ERIE_DEFER && i_ev_write
     && i_feat.defer == FEAT_SPLIT && st.ctl[CTL_DEF_WR_BIT])
      |=> o_recov_irq) else $error("deferred write irq missing");
  chk_defer_rd: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && i_ev_valid && i_ev_class == ERIE_DEFER && !i_ev_write
     && i_feat.defer == FEAT_SPLIT && !st.ctl[CTL_DEF_RD_BIT])
      |=> !o_recov_irq) else $error("deferred read irq wrong");
  chk_defer_all: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && i_ev_valid && i_ev_class == ERIE_DEFER
     && i_feat.defer == FEAT_COMBINED && st.ctl[CTL_DEF_RD_BIT])
      |=> o_recov_irq) else $error("deferred irq missing");
  chk_uncorr_wr: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && i_ev_valid && i_ev_class == ERIE_UNCORR && i_ev_write
     && i_feat.uncorr == FEAT_SPLIT && st.ctl[CTL_UNC_WR_BIT])
      |=> o_recov_irq) else $error("uncorr write irq missing");
  chk_corr_all: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && i_ev_valid && i_ev_class == ERIE_CORR && !i_cnt_present
     && i_feat.corr == FEAT_COMBINED && st.ctl[CTL_COR_RD_BIT]) |=> o_fault_irq)
    else $error("corrected fault irq missing");
  chk_corr_wr: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && i_ev_valid && i_ev_class == ERIE_CORR && i_ev_write && !i_cnt_present
     && i_feat.corr == FEAT_SPLIT && st.ctl[CTL_COR_WR_BIT]) |=> o_fault_irq)
    else $error("write corrected fault irq missing");
  chk_corr_rd: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && i_ev_valid && i_ev_class == ERIE_CORR && !i_ev_write
     && (!i_cnt_present || i_ev_ovf)
     && i_feat.corr == FEAT_SPLIT && st.ctl[CTL_COR_RD_BIT]) |=> o_fault_irq)
    else $error("read corrected fault irq missing");
  chk_flt_wr: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && i_ev_valid && i_ev_class != ERIE_CORR && i_ev_write
     && i_feat.fault == FEAT_SPLIT && st.ctl[CTL_FLT_WR_BIT]) |=> o_fault_irq)
    else $error("write fault irq missing");
  chk_recov_keep: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && i_err_recov_rst && !i_ctl_wr)
      |=> (o_ctl_rdata == ($past(o_ctl_rdata) & $past(impl_mask))))
    else $error("enables lost on recovery reset");
  chk_quiet_idle: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && !i_ev_valid)
      |=> !(o_crit_irq || o_recov_irq || o_fault_irq || o_ext_abort || o_uncontained))
    else $error("interrupt without event");
  chk_resv_zero: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && i_feat.crit != FEAT_COMBINED) |=> !o_ctl_rdata[CTL_CRIT_EN_BIT])
    else $error("reserved not zero");
endmodule
`default_nettype wire

/* File: erie_pkg.sv */
// Purpose: Shared constants for the error record enable block
// Assumes: Feature codes are two-bit fields of the feature descriptor
// Notes:   Control register bits 13..4 only
package erie_pkg;
  // Control register field positions
  localparam int unsigned CTL_CRIT_EN_BIT = 13;
  localparam int unsigned CTL_DEF_WR_BIT  = 11;
  localparam int unsigned CTL_DEF_RD_BIT  = 10;
  localparam int unsigned CTL_COR_WR_BIT  = 9;
  localparam int unsigned CTL_COR_RD_BIT  = 8;
  localparam int unsigned CTL_ABT_WR_BIT  = 7;
  localparam int unsigned CTL_FLT_WR_BIT  = 6;
  localparam int unsigned CTL_UNC_WR_BIT  = 5;
  localparam int unsigned CTL_ABT_RD_BIT  = 4;
  // Outside this block's range; always masked, so read/combined fault enable stays off
  localparam int unsigned CTL_FLT_RD_BIT  = 3;
  localparam int unsigned CTL_WIDTH    = 64;
  // Feature descriptor codes
  localparam logic [1:0] FEAT_NONE     = 2'h0;
  localparam logic [1:0] FEAT_COMBINED = 2'h2;
  localparam logic [1:0] FEAT_SPLIT    = 2'h3;
  // Cold reset value, architecturally unknown, chosen as zero
  localparam logic [CTL_WIDTH-1:0] CTL_RESET = 64'h0;

  // Error class of an event
  typedef enum logic [1:0] {ERIE_CORR, ERIE_DEFER, ERIE_UNCORR} erie_class_t;

  typedef struct packed {
    logic [1:0] crit;
    logic [1:0] defer;
    logic [1:0] corr;
    logic [1:0] abort;
    logic [1:0] fault;
    logic [1:0] uncorr;
  } erie_feat_t;
endpackage

/* File: erie_ev_if.sv */
// Purpose: Carries one qualified error event between block modules
// Assumes: Single clock
// Notes:   One-cycle event strobes
`timescale 1ns/1ps
`default_nettype none
interface erie_ev_if;
  logic crit_irq;
  logic recov_irq;
  logic fault_irq;
  logic abort;
  modport src (output crit_irq, output recov_irq, output fault_irq, output abort);
  modport dst (input crit_irq, input recov_irq, input fault_irq, input abort);
endinterface
`default_nettype wire

/* File: erie_decode.sv */
// Purpose: Combinational qualification of error events against enables
// Assumes: Enables already masked by the feature descriptor
// Notes:   Purely combinational; top registers outputs
`timescale 1ns/1ps
`default_nettype none
module erie_decode
  import erie_pkg::*;
(
  // Enables and features
  input  wire logic [CTL_WIDTH-1:0] i_ctl,
  input  wire erie_feat_t           i_feat,
  input  wire logic                 i_cnt_present,
  // Event
  input  wire logic                 i_ev_valid,
  input  wire erie_class_t          i_ev_class,
  input  wire logic                 i_ev_write,
  input  wire logic                 i_ev_crit,
  input  wire logic                 i_ev_ovf,
  // Qualified
  erie_ev_if.src                    ev
);
  // Pick the control that covers this access direction
  function automatic logic dir_en(input logic [1:0] code, input logic wr,
                                  input logic wbit, input logic rbit);
    if (code == FEAT_SPLIT)
      dir_en = wr ? wbit : rbit;
    else if (code == FEAT_COMBINED)
      dir_en = rbit;
    else
      dir_en = 1'b0;
  endfunction

  logic corr_hit;
  logic flt_en;
  logic cor_en;

  always_comb
  begin
    // Counted nodes signal only on overflow
    corr_hit = (i_ev_class == ERIE_CORR) && (!i_cnt_present || i_ev_ovf);
    flt_en   = dir_en(i_feat.fault, i_ev_write, i_ctl[CTL_FLT_WR_BIT], i_ctl[CTL_FLT_RD_BIT]);
    cor_en   = dir_en(i_feat.corr, i_ev_write, i_ctl[CTL_COR_WR_BIT], i_ctl[CTL_COR_RD_BIT]);
  end

  assign ev.crit_irq  = i_ev_valid && i_ev_crit && i_ctl[CTL_CRIT_EN_BIT];
  assign ev.recov_irq = i_ev_valid &&
    (((i_ev_class == ERIE_DEFER) &&
      dir_en(i_feat.defer, i_ev_write, i_ctl[CTL_DEF_WR_BIT], i_ctl[CTL_DEF_RD_BIT])) ||
     ((i_ev_class == ERIE_UNCORR) && i_ev_write && (i_feat.uncorr == FEAT_SPLIT) &&
      i_ctl[CTL_UNC_WR_BIT]));
  assign ev.fault_irq = i_ev_valid &&
    ((corr_hit && cor_en) ||
     (flt_en &&
      ((i_ev_class != ERIE_CORR) || (corr_hit && (i_feat.corr == FEAT_NONE)))));
  assign ev.abort = i_ev_valid && (i_ev_class == ERIE_UNCORR) &&
    (((i_feat.abort == FEAT_SPLIT) && i_ev_write && i_ctl[CTL_ABT_WR_BIT]) ||
     ((i_feat.abort == FEAT_COMBINED) && i_ctl[CTL_ABT_RD_BIT]));
endmodule
`default_nettype wire

/* File: erie_far_model.sv */
// Purpose: Far-side model of interrupt controller and requester
// Assumes: Outputs of the block are sampled on the rising clock edge
// Notes:   A line held high too long shows up as an inflated count
`timescale 1ns/1ps
`default_nettype none
module erie_far_model
(
  // Clock and reset
  input  wire logic            i_clk_sys,
  input  wire logic            i_rst,
  // Critical, recovery, fault, abort, uncontained
  input  wire logic [4:0]      i_sig,
  // Pulse counts per line
  output logic      [4:0][7:0] o_cnt
);
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_cnt <= '0;
    end
    else
    begin
      for (int i = 0; i < 5; i++)
      begin
        o_cnt[i] <= o_cnt[i] + {7'h0, i_sig[i]};
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb_error_record_irq_abort_enables.sv */
// Purpose: Self-checking bench for the control enable block
// Assumes: Inputs change on the falling edge only
// Notes:   Each event rewrites the control word first
`timescale 1ns/1ps
`default_nettype none
module tb_error_record_irq_abort_enables;
  import erie_pkg::*;
  localparam erie_feat_t F_SPLIT = '{2'h2, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3};
  localparam erie_feat_t F_COMB  = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h0, 2'h0};
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic i_ce = 1'b1;
  logic i_err_recov_rst = 1'b0;
  erie_feat_t i_feat = F_SPLIT;
  logic i_cnt_present = 1'b0;
  logic i_ctl_wr = 1'b0;
  logic [63:0] i_ctl_wdata = '0;
  logic i_ev_valid = 1'b0;
  erie_class_t i_ev_class = ERIE_CORR;
  logic i_ev_write = 1'b0;
  logic i_ev_crit = 1'b0;
  logic i_ev_ovf = 1'b0;
  logic i_ev_syn_dropped = 1'b0;
  logic [63:0] o_ctl_rdata;
  logic o_crit_irq, o_recov_irq, o_fault_irq, o_ext_abort, o_uncontained;
  logic [4:0][7:0] far_cnt;
  logic [4:0][7:0] tally = '0;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;

  erie_top DUT (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(i_ce),
    .i_err_recov_rst(i_err_recov_rst), .i_feat(i_feat), .i_cnt_present(i_cnt_present),
    .i_ctl_wr(i_ctl_wr), .i_ctl_wdata(i_ctl_wdata), .o_ctl_rdata(o_ctl_rdata),
    .i_ev_valid(i_ev_valid), .i_ev_class(i_ev_class), .i_ev_write(i_ev_write),
    .i_ev_crit(i_ev_crit), .i_ev_ovf(i_ev_ovf), .i_ev_syn_dropped(i_ev_syn_dropped),
    .o_crit_irq(o_crit_irq), .o_recov_irq(o_recov_irq), .o_fault_irq(o_fault_irq),
    .o_ext_abort(o_ext_abort), .o_uncontained(o_uncontained));
  erie_far_model far (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .o_cnt(far_cnt),
    .i_sig({o_crit_irq, o_recov_irq, o_fault_irq, o_ext_abort, o_uncontained}));

  always #20 i_clk_sys = ~i_clk_sys;

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Run is under a hundred cycles; the ceiling leaves wide margin
  always @(posedge i_clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      err_count++;
      conclude();
    end
  end

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wctl(input logic [63:0] val);
    i_ctl_wr = 1'b1;
    i_ctl_wdata = val;
    @(negedge i_clk_sys);
    i_ctl_wr = 1'b0;
  endtask

  // Extra idle cycle so the registered read path has settled
  task automatic rd(input logic [63:0] exp);
    @(negedge i_clk_sys);
    check("control read", o_ctl_rdata, exp);
  endtask

  // Drop flag toggles every call: outputs must not depend on it
  task automatic ev(input logic [63:0] ctl, input erie_class_t cls, input logic wr,
                    input logic cr, input logic ov, input logic [4:0] exp);
    wctl(ctl);
    i_ev_valid = 1'b1;
    i_ev_class = cls;
    i_ev_write = wr;
    i_ev_crit = cr;
    i_ev_ovf = ov;
    @(negedge i_clk_sys);
    check("event outputs", {59'h0, o_crit_irq, o_recov_irq, o_fault_irq, o_ext_abort,
          o_uncontained}, {59'h0, exp});
    i_ev_valid = 1'b0;
    i_ev_syn_dropped = ~i_ev_syn_dropped;
    for (int i = 0; i < 5; i++)
      tally[i] += {7'h0, exp[i]};
  endtask

  initial
  begin
    repeat (10) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    i_rst = 1'b0;
    wctl('1);
    rd(64'h2ff0);
    ev(64'h2000, ERIE_CORR, 1'b0, 1'b1, 1'b0, 5'h10);
    ev(64'h0, ERIE_CORR, 1'b0, 1'b1, 1'b0, 5'h01);
    ev(64'h800, ERIE_DEFER, 1'b1, 1'b0, 1'b0, 5'h08);
    ev(64'h800, ERIE_DEFER, 1'b0, 1'b0, 1'b0, 5'h00);
    ev(64'h400, ERIE_DEFER, 1'b0, 1'b0, 1'b0, 5'h08);
    ev(64'h400, ERIE_DEFER, 1'b1, 1'b0, 1'b0, 5'h00);
    ev(64'h200, ERIE_CORR, 1'b1, 1'b0, 1'b0, 5'h04);
    ev(64'h200, ERIE_CORR, 1'b0, 1'b0, 1'b0, 5'h00);
    ev(64'h100, ERIE_CORR, 1'b0, 1'b0, 1'b0, 5'h04);
    ev(64'h100, ERIE_CORR, 1'b1, 1'b0, 1'b0, 5'h00);
    ev(64'h80, ERIE_UNCORR, 1'b1, 1'b0, 1'b0, 5'h02);
    ev(64'h0, ERIE_UNCORR, 1'b1, 1'b0, 1'b0, 5'h00);
    ev(64'h40, ERIE_DEFER, 1'b1, 1'b0, 1'b0, 5'h04);
    ev(64'h40, ERIE_UNCORR, 1'b1, 1'b0, 1'b0, 5'h04);
    ev(64'h40, ERIE_DEFER, 1'b0, 1'b0, 1'b0, 5'h00);
    ev(64'h20, ERIE_UNCORR, 1'b1, 1'b0, 1'b0, 5'h08);
    ev(64'h20, ERIE_UNCORR, 1'b0, 1'b0, 1'b0, 5'h00);
    i_feat = F_COMB;
    i_cnt_present = 1'b1;
    ev(64'h400, ERIE_DEFER, 1'b1, 1'b0, 1'b0, 5'h08);
    ev(64'h400, ERIE_DEFER, 1'b0, 1'b0, 1'b0, 5'h08);
    ev(64'h100, ERIE_CORR, 1'b0, 1'b0, 1'b1, 5'h04);
    ev(64'h100, ERIE_CORR, 1'b1, 1'b0, 1'b0, 5'h00);
    ev(64'h10, ERIE_UNCORR, 1'b0, 1'b0, 1'b0, 5'h02);
    ev(64'h10, ERIE_UNCORR, 1'b1, 1'b0, 1'b0, 5'h02);
    wctl('1);
    rd(64'h2510);
    i_err_recov_rst = 1'b1;
    @(negedge i_clk_sys);
    i_err_recov_rst = 1'b0;
    rd(64'h2510);
    i_ce = 1'b0;
    wctl('0);
    i_ce = 1'b1;
    rd(64'h2510);
    check("pulse counts", {24'h0, far_cnt}, {24'h0, tally});
    i_feat = '0;
    wctl('1);
    rd(64'h0);
    i_feat = F_SPLIT;
    wctl('1);
    i_rst = 1'b1;
    @(negedge i_clk_sys);
    check("control after reset", o_ctl_rdata, 64'h0);
    i_rst = 1'b0;
    conclude();
  end
endmodule
`default_nettype wire
